// ===== verilog/adccal_pkg.sv
// Purpose: shared constants and types for the converter calibration and offset-null control
// Assumes: single 10 MHz conversion clock, APB register access
// Notes:   counts are derived from times where a time is specified
package adccal_pkg;

    // clock and calibration timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CAL_TIME_MS     = 15;
    localparam int unsigned CAL_CYCLES_DFLT = CAL_TIME_MS * (CLK_HZ / 1000);
    localparam int          CNT_W           = 18;

    // conversion sequencing, in clock periods
    localparam logic [CNT_W-1:0] CONV_HOLD_CYCLES   = 18'h0000D; // hold command high
    localparam logic [CNT_W-1:0] CONV_IGNORE_CYCLES = 18'h00007; // start ignored after hold falls
    localparam logic [CNT_W-1:0] RECOV_CYCLES       = 18'h00011; // 17 after calibration
    localparam logic [CNT_W-1:0] CNT_ONE            = 18'h00001;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0C;

    // control register fields and reset value
    localparam int          CTRL_FMT_BIT     = 0;
    localparam int          CTRL_CONV_EN_BIT = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h2;

    // result arithmetic limits and format anchors
    localparam logic signed [16:0] SAT_POS_17 = 17'sh07FFF;
    localparam logic signed [16:0] SAT_NEG_17 = -17'sh08000;
    localparam logic signed [15:0] SAT_POS    = 16'sh7FFF;
    localparam logic signed [15:0] SAT_NEG    = 16'sh8000;
    localparam logic signed [17:0] MID_COB    = 18'sh08000;
    localparam logic signed [17:0] MAX_COB    = 18'sh0FFFF;
    localparam logic        [15:0] ALL_ONES   = 16'hFFFF;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CONV  = 5'b00010,
        ST_IGN   = 5'b00100,
        ST_CAL   = 5'b01000,
        ST_RECOV = 5'b10000
    } adccal_state_t;

    // status word as read by software
    typedef struct packed {
        logic offset_valid;
        logic null_armed;
        logic first_done;
        logic cal_pending;
        logic recovering;
        logic ignoring;
        logic converting;
        logic cal_busy;
    } adccal_status_t;

endpackage

// ===== verilog/adccal_fmt.sv
// Purpose: offset subtraction, saturation and output coding of one result
// Assumes: sample is a true two's complement value, zero input reads zero
// Notes:   purely combinational; the caller registers the code
`timescale 1ns/1ps
`default_nettype none
module adccal_fmt (
    input  wire logic signed [15:0] sample,   // uncorrected result
    input  wire logic        [15:0] offset,   // stored zeroing result
    input  wire logic               apply,    // subtract the offset
    input  wire logic               fmt_sel,  // output_format_sel
    output logic             [15:0] code      // coded output word
);
    import adccal_pkg::*;

    logic signed [16:0] diff;
    logic signed [15:0] val;
    logic signed [17:0] cob;

    // widen before subtracting so an overflow is seen and clamped, never wrapped
    always_comb begin
        diff = {sample[15], sample} - (apply ? $signed({offset[15], offset}) : 17'sh00000);
        if (diff > SAT_POS_17) begin
            val = SAT_POS;
        end else if (diff < SAT_NEG_17) begin
            val = SAT_NEG;
        end else begin
            val = diff[15:0];
        end
        cob = MID_COB - $signed({{2{val[15]}}, val});
        if (!fmt_sel) begin
            code = ~val;
        end else if (cob > MAX_COB) begin
            code = ALL_ONES;
        end else begin
            code = cob[15:0];
        end
    end

endmodule
`default_nettype wire

// ===== verilog/adccal_ctrl.sv
// Purpose: calibration sequencer, conversion timing and offset-null control, APB registers
// Assumes: pins are synchronous to pclk; the converter core supplies adc_sample at
//          the end of each hold period
// Notes:   calibration length is a parameter so simulation can shorten it
//
// Overview of operation
// - a low calibration request is accepted at any time.
// - a request during a conversion waits and starts right after it ends.
// - when idle, calibration starts at the first edge after the request.
// - calibration request always beats a simultaneous conversion request.
// - calibration status is high from cycle start until the cycle ends.
// - requests while calibrating do not disturb the running cycle.
// - one calibration lasts a fixed count, about 15 ms at 10 MHz.
// - calibration never touches the stored offset.
// - 17 clock periods of recovery follow each calibration.
// - conversion requests in the recovery interval are ignored.
// - a held request repeats calibration cycles back to back.
// - on release, finish the cycle, recover 17 clocks, then convert.
// - store a zeroing result and subtract it from later results.
// - nulled zero reads zero (twos) or midscale (offset binary); the code gives all ones (FFFF) in twos.
// - offset captured at the first strobe after the control goes high.
// - the captured offset is also shown on the data output.
// - while the control stays high, results are corrected.
// - control low clears the offset and restores uncorrected data.
// - nulling cannot arm before the first conversion completes.
// - format select low gives complementary twos, high offset binary.
// - corrected results saturate at all zeros or all ones; the code stops at 8000/7FFF (twos) or 0001/FFFF (offset binary).
// - hold falling ends a conversion; start is ignored seven periods.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adccal_ctrl #(
    parameter int unsigned CAL_CYCLES = adccal_pkg::CAL_CYCLES_DFLT // calibration length
) (
    input  wire logic               pclk,          // conversion clock, 10 MHz
    input  wire logic               presetn,       // async reset, active low
    input  wire logic               psel,          // APB select
    input  wire logic               penable,       // APB access phase
    input  wire logic               pwrite,        // APB direction
    input  wire logic [7:0]         paddr,         // APB byte address
    input  wire logic [31:0]        pwdata,        // APB write data
    output logic      [31:0]        prdata,        // APB read data
    output logic                    pready,        // APB ready
    output logic                    pslverr,       // APB error, unmapped
    input  wire logic               cal_req_n,     // calibration request, active low
    input  wire logic               start_conv,    // conversion request
    input  wire logic               offset_null_n, // offset-null control, high enables
    input  wire logic signed [15:0] adc_sample,    // raw result from the core
    output logic                    hold_cmd,      // hold command, high while converting
    output logic                    cal_status,    // calibration in progress
    output logic                    data_strobe,   // result strobe, one cycle
    output logic      [15:0]        data_out       // coded result
);
    import adccal_pkg::*;

    localparam logic [CNT_W-1:0] CAL_LOAD = CNT_W'(CAL_CYCLES - 1);

    adccal_state_t    state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic             pend_r, pend_nxt;
    logic             strobe_r, strobe_nxt;
    logic [1:0]       ctrl_r, ctrl_nxt;
    logic [15:0]      off_r, off_nxt;
    logic             valid_r, valid_nxt;
    logic             armed_r, armed_nxt;
    logic             first_r, first_nxt;
    logic signed [15:0] raw_r, raw_nxt;
    logic [15:0]      data_r, data_nxt;
    logic [31:0]      prdata_r, prdata_nxt;
    logic             conv_end;
    logic             capture;
    logic             cal_want;
    logic             start_ok;
    logic signed [15:0] fmt_src;
    logic             fmt_apply;
    logic [15:0]      fmt_code;
    adccal_status_t   status;

    // request decode: calibration wins over start in every state
    assign cal_want = ~cal_req_n | pend_r;
    assign start_ok = start_conv & ctrl_r[CTRL_CONV_EN_BIT] & ~cal_want;
    assign conv_end = (state_r == ST_CONV) && (cnt_r == '0);

    // sequencer next state; every timed state loads its count on entry
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == '0) ? cnt_r : cnt_r - CNT_ONE;
        pend_nxt  = pend_r;
        case (state_r)
            ST_IDLE: begin
                if (cal_want) begin
                    state_nxt = ST_CAL;
                    cnt_nxt   = CAL_LOAD;
                end else if (start_ok) begin
                    state_nxt = ST_CONV;
                    cnt_nxt   = CONV_HOLD_CYCLES - CNT_ONE;
                end
            end
            ST_CONV: begin
                // a request now is held until the conversion ends
                if (!cal_req_n) begin
                    pend_nxt = 1'b1;
                end
                if (cnt_r == '0) begin
                    if (cal_want || !cal_req_n) begin
                        state_nxt = ST_CAL;
                        cnt_nxt   = CAL_LOAD;
                    end else begin
                        state_nxt = ST_IGN;
                        cnt_nxt   = CONV_IGNORE_CYCLES - CNT_ONE;
                    end
                end
            end
            ST_IGN: begin
                // start is looked at only from the seventh edge after hold falls
                if (cal_want) begin
                    state_nxt = ST_CAL;
                    cnt_nxt   = CAL_LOAD;
                end else if (cnt_r == '0) begin
                    if (start_ok) begin
                        state_nxt = ST_CONV;
                        cnt_nxt   = CONV_HOLD_CYCLES - CNT_ONE;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_CAL: begin
                // fresh requests are not latched; only the level at the end counts
                pend_nxt = 1'b0;
                if (cnt_r == '0) begin
                    if (!cal_req_n) begin
                        cnt_nxt = CAL_LOAD;
                    end else begin
                        state_nxt = ST_RECOV;
                        cnt_nxt   = RECOV_CYCLES - CNT_ONE;
                    end
                end
            end
            ST_RECOV: begin
                // start is ignored here; a new calibration request may still begin
                if (!cal_req_n) begin
                    state_nxt = ST_CAL;
                    cnt_nxt   = CAL_LOAD;
                end else if (cnt_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt   = '0;
                pend_nxt  = 1'b0;
            end
        endcase
        strobe_nxt = (state_r == ST_CONV) && (cnt_r == '0);
    end

    // sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= ST_IDLE;
            cnt_r    <= '0;
            pend_r   <= 1'b0;
            strobe_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            pend_r   <= pend_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    // offset-null control: capture on the strobe that follows arming
    assign capture = conv_end & offset_null_n & armed_r & first_r;

    always_comb begin
        off_nxt   = off_r;
        valid_nxt = valid_r;
        armed_nxt = armed_r;
        first_nxt = first_r | conv_end;
        raw_nxt   = conv_end ? adc_sample : raw_r;
        if (!offset_null_n) begin
            off_nxt   = '0;
            valid_nxt = 1'b0;
            armed_nxt = first_r;
        end else if (capture) begin
            off_nxt   = adc_sample;
            valid_nxt = 1'b1;
            armed_nxt = 1'b0;
        end
        // calibration states leave off_r alone on purpose
        if (state_r == ST_CAL) begin
            off_nxt = off_nxt;
        end
    end

    // one formatter serves new results and the revert on clear
    assign fmt_src   = conv_end ? adc_sample : raw_r;
    assign fmt_apply = offset_null_n & valid_r & ~capture;

    adccal_fmt u_fmt (
        .sample  (fmt_src),
        .offset  (off_r),
        .apply   (fmt_apply),
        .fmt_sel (ctrl_r[CTRL_FMT_BIT]),
        .code    (fmt_code)
    );

    // output data register: new result, or uncorrected copy when nulling stops
    always_comb begin
        data_nxt = data_r;
        if (conv_end) begin
            data_nxt = fmt_code;
        end else if (!offset_null_n && valid_r) begin
            data_nxt = fmt_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_r   <= '0;
            valid_r <= 1'b0;
            armed_r <= 1'b0;
            first_r <= 1'b0;
            raw_r   <= '0;
            data_r  <= '0;
        end else begin
            off_r   <= off_nxt;
            valid_r <= valid_nxt;
            armed_r <= armed_nxt;
            first_r <= first_nxt;
            raw_r   <= raw_nxt;
            data_r  <= data_nxt;
        end
    end

    // status word for software
    always_comb begin
        status              = '0;
        status.cal_busy     = (state_r == ST_CAL);
        status.converting   = (state_r == ST_CONV);
        status.ignoring     = (state_r == ST_IGN);
        status.recovering   = (state_r == ST_RECOV);
        status.cal_pending  = pend_r;
        status.first_done   = first_r;
        status.null_armed   = armed_r;
        status.offset_valid = valid_r;
    end

    // APB: read data latched in the setup phase so it comes from a flop;
    // zero wait states, unmapped addresses answer with pslverr
    always_comb begin
        ctrl_nxt   = ctrl_r;
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CTRL:   prdata_nxt = {30'h0, ctrl_r};
                ADDR_STATUS: prdata_nxt = {24'h0, status};
                ADDR_RESULT: prdata_nxt = {16'h0, data_r};
                ADDR_OFFSET: prdata_nxt = {16'h0, off_r};
                default:     prdata_nxt = 32'h0;
            endcase
        end
        if (psel && penable && pwrite && (paddr == ADDR_CTRL)) begin
            ctrl_nxt = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= CTRL_RESET;
            prdata_r <= 32'h0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready      = 1'b1;
    assign pslverr     = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_STATUS)
                         & (paddr != ADDR_RESULT) & (paddr != ADDR_OFFSET);
    assign prdata      = prdata_r;
    assign hold_cmd    = (state_r == ST_CONV);
    assign cal_status  = (state_r == ST_CAL);
    assign data_strobe = strobe_r;
    assign data_out    = data_r;

endmodule
`default_nettype wire

// ===== verif/adccal_chk.sv
// Purpose: concurrent checks on the converter control pins
// Assumes: one domain on pclk, presetn async active low
// Notes:   calibration length comes in through the bind
`timescale 1ns/1ps
`default_nettype none
module adccal_chk #(
    parameter int unsigned CAL_CYCLES = 40 // calibration length
) (
    input wire logic pclk,        // clock
    input wire logic presetn,     // reset, active low
    input wire logic cal_req_n,   // calibration request
    input wire logic start_conv,  // conversion request
    input wire logic hold_cmd,    // converting
    input wire logic cal_status,  // calibrating
    input wire logic data_strobe  // result strobe
);
    logic [31:0] cal_cnt_r;
    logic [31:0] cal_cnt_nxt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // length of the current calibration run; back-to-back runs add up
    always_comb cal_cnt_nxt = cal_status ? cal_cnt_r + 32'h00000001 : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cal_cnt_r <= 32'h00000000;
        else cal_cnt_r <= cal_cnt_nxt;
    end

    // quiet span after calibration and the full hold period
    sequence s_quiet17;
        !hold_cmd [*8] ##1 !hold_cmd [*8] ##1 !hold_cmd;
    endsequence
    sequence s_hold13;
        hold_cmd [*8] ##1 hold_cmd [*5] ##1 !hold_cmd;
    endsequence

    chk_cal_idle_go: assert property (!cal_req_n && !hold_cmd && !cal_status |=> cal_status)
        else $error("calibration did not start from idle");
    chk_cal_beats_conv: assert property (!cal_req_n && start_conv && !hold_cmd && !cal_status
        |=> !hold_cmd)
        else $error("conversion won over calibration");
    chk_cal_pending: assert property (hold_cmd && !cal_req_n |-> ##[1:14] cal_status)
        else $error("pending calibration did not follow the conversion");
    chk_no_conv_cal: assert property (cal_status |-> !hold_cmd)
        else $error("conversion during calibration");
    chk_cal_length: assert property ($fell(cal_status)
        |-> (cal_cnt_r != 0) && (cal_cnt_r % CAL_CYCLES == 0))
        else $error("calibration length wrong");
    chk_recov_gap: assert property ($fell(cal_status) |-> s_quiet17)
        else $error("conversion inside recovery");
    chk_hold_len: assert property ($rose(hold_cmd) |-> s_hold13)
        else $error("hold period length wrong");
    chk_ignore_seven: assert property ($fell(hold_cmd) |-> !hold_cmd [*7])
        else $error("start taken inside ignore span");
    chk_strobe_end: assert property (data_strobe == $fell(hold_cmd))
        else $error("strobe not at conversion end");
endmodule

bind adccal_ctrl adccal_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .cal_req_n(cal_req_n), .start_conv(start_conv),
    .hold_cmd(hold_cmd), .cal_status(cal_status), .data_strobe(data_strobe));
`default_nettype wire

// ===== verif/adccal_host.sv
// Purpose: host logic model driving the control pins
// Assumes: pins change just after a rising edge
// Notes:   start is masked while calibrating, as the host should do
`timescale 1ns/1ps
`default_nettype none
module adccal_host (
    input  wire logic pclk,          // clock
    input  wire logic presetn,       // reset, active low
    input  wire logic want_cal,      // bench asks for calibration
    input  wire logic want_conv,     // bench asks for conversions
    input  wire logic want_null,     // bench asks for nulling
    input  wire logic cal_status,    // calibration in progress
    output logic      cal_req_n,     // calibration request
    output logic      start_conv,    // conversion request
    output logic      offset_null_n  // offset-null control
);
    // registered pins; nulling stays off until asked for
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_req_n     <= 1'b1;
            start_conv    <= 1'b0;
            offset_null_n <= 1'b0;
        end else begin
            cal_req_n     <= !want_cal;
            start_conv    <= want_conv && !cal_status;
            offset_null_n <= want_null;
        end
    end
endmodule
`default_nettype wire

// ===== verif/adccal_ctrl_tb.sv
// Purpose: self-checking bench for calibration and offset-null control
// Assumes: calibration shortened to 40 clocks
// Notes:   drivers queue expected codes; a monitor checks each strobe
`timescale 1ns/1ps
`default_nettype none
module adccal_ctrl_tb;
    import adccal_pkg::*;
    localparam int unsigned CAL_N = 40;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic        [7:0]  paddr = 8'h00;
    logic        [31:0] pwdata = 32'h00000000;
    logic               want_cal = 1'b0;
    logic               want_conv = 1'b0;
    logic               want_null = 1'b0;
    logic signed [15:0] raw_r = 16'sh0000;
    logic               fmt_r = 1'b0;
    logic        [31:0] prdata;
    logic               pready;
    logic               pslverr;
    logic               cal_req_n;
    logic               start_conv;
    logic               offset_null_n;
    logic               hold_cmd;
    logic               cal_status;
    logic               data_strobe;
    logic        [15:0] data_out;
    logic        [15:0] exp_q[$];
    int                 err_total = 0;
    int                 comparisons = 0;
    int                 i;

    adccal_ctrl #(.CAL_CYCLES(CAL_N)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cal_req_n(cal_req_n),
        .start_conv(start_conv), .offset_null_n(offset_null_n), .adc_sample(raw_r),
        .hold_cmd(hold_cmd), .cal_status(cal_status), .data_strobe(data_strobe),
        .data_out(data_out));
    adccal_host u_host (.pclk(pclk), .presetn(presetn), .want_cal(want_cal),
        .want_conv(want_conv), .want_null(want_null), .cal_status(cal_status),
        .cal_req_n(cal_req_n), .start_conv(start_conv), .offset_null_n(offset_null_n));

    // 10 MHz clock
    initial begin
        forever #50 pclk = ~pclk;
    end

    // expected code: subtract, saturate, then apply the output format
    function automatic logic [15:0] code_of(input logic signed [15:0] v,
                                            input logic signed [15:0] o, input logic f);
        logic signed [17:0] d;
        d = 18'(v) - 18'(o);
        if (d > 18'sh07FFF) d = 18'sh07FFF;
        if (d < -18'sh08000) d = -18'sh08000;
        if (!f) return ~d[15:0];
        d = 18'sh08000 - d;
        return (d > 18'sh0FFFF) ? 16'hFFFF : d[15:0];
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, want);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask

    task automatic set_fmt(input logic f);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ADDR_CTRL, {30'h0, 1'b1, f}, r, e);
        fmt_r = f;
    endtask

    // one conversion; the code expected at its strobe is queued first
    task automatic conv(input logic signed [15:0] v, input logic signed [15:0] o);
        int n;
        n = 0;
        raw_r <= v;
        exp_q.push_back(code_of(v, o, fmt_r));
        want_conv <= 1'b1;
        @(posedge pclk);
        while (hold_cmd !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        want_conv <= 1'b0;
        while (hold_cmd === 1'b1) @(posedge pclk);
        repeat (8) @(posedge pclk);
    endtask

    task automatic cal_wait();
        repeat (2) @(posedge pclk);
        while (cal_status === 1'b1) @(posedge pclk);
        repeat (20) @(posedge pclk);
    endtask

    task automatic pulse_cal();
        want_cal <= 1'b1;
        @(posedge pclk);
        want_cal <= 1'b0;
    endtask

    task automatic tally_and_finish();
        if (exp_q.size() != 0) err_total++;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // result monitor: each strobe takes the oldest queued code
    always @(posedge pclk) begin
        if (data_strobe === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("[ERR] %0t strobe with nothing expected", $time);
            end else check({16'h0, data_out}, {16'h0, exp_q.pop_front()});
        end
    end

    // cut a hang short
    initial begin
        repeat (30000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(19));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CTRL, {30'h0, CTRL_RESET}, 1'b0);
        rd_chk(ADDR_STATUS, 32'h00000000, 1'b0);
        rd_chk(8'h10, 32'h00000000, 1'b1);
        $display("test reset done");
        // nulling asked for before the first conversion must stay inert
        want_null <= 1'b1;
        for (i = 0; i < 8; i++) begin
            set_fmt(i[0]);
            conv((i == 6) ? 16'sh7FFF : (i == 7) ? 16'sh8000 : 16'($urandom), 16'sh0000);
        end
        rd_chk(ADDR_OFFSET, 32'h00000000, 1'b0);
        $display("test formats done");
        for (i = 0; i < 2; i++) begin
            set_fmt(i[0]);
            want_null <= 1'b0;
            repeat (3) @(posedge pclk);
            want_null <= 1'b1;
            conv(16'sh012C, 16'sh0000);
            conv(16'sh012C, 16'sh012C);
            conv(16'sh8000, 16'sh012C);
        end
        rd_chk(ADDR_OFFSET, 32'h0000012C, 1'b0);
        $display("test nulling done");
        // second request inside the running cycle must not disturb it
        pulse_cal();
        repeat (12) @(posedge pclk);
        pulse_cal();
        cal_wait();
        rd_chk(ADDR_OFFSET, 32'h0000012C, 1'b0);
        conv(16'sh012C, 16'sh012C);
        fork
            conv(16'sh0100, 16'sh012C);
            begin
                while (hold_cmd !== 1'b1) @(posedge pclk);
                pulse_cal();
            end
        join
        cal_wait();
        // held request repeats cycles; the held start waits for recovery
        want_cal <= 1'b1;
        fork
            conv(16'sh0055, 16'sh012C);
            begin
                repeat (100) @(posedge pclk);
                want_cal <= 1'b0;
            end
        join
        $display("test calibration done");
        want_null <= 1'b0;
        repeat (3) @(posedge pclk);
        check({16'h0, data_out}, {16'h0, code_of(16'sh0055, 16'sh0000, fmt_r)});
        rd_chk(ADDR_OFFSET, 32'h00000000, 1'b0);
        conv(16'sh012C, 16'sh0000);
        $display("test clearing done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
